// ===== sdio_far_model.sv
`timescale 1ns/10ps
`default_nettype none

// Far side of the port: pin sources, pull-ups and the two converters
module sdio_far_model
(
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_pins_out,    // Device drive value
  input  wire logic [15:0] i_pins_oe,     // Device drive enable
  input  wire logic [15:0] i_ext,         // External source level
  input  wire logic        i_ext_en,      // External source active
  output var  logic [15:0] o_pins,        // Resolved pin level
  output var  logic        o_ain_strobe,  // A/D sample taken
  output var  logic [11:0] o_ain0,        // Channel 0 sample
  output var  logic [11:0] o_ain1,        // Channel 1 sample
  output var  logic        o_aout_strobe, // D/A sample taken
  output var  logic [15:0] o_aout1_word   // Output channel 1 word
);
  // Device wins where it drives; elsewhere the external source, or the pull-up while that source is off
  always_comb
  begin
    o_pins = i_ext_en ? i_ext : 16'hffff;
    o_pins = (i_pins_oe & i_pins_out) | (~i_pins_oe & o_pins);
  end

  // Quiet converters at time zero
  initial
  begin
    o_ain_strobe  = 1'b0;
    o_aout_strobe = 1'b0;
    o_ain0        = 12'h000;
    o_ain1        = 12'h000;
    o_aout1_word  = 16'h0000;
  end

  // One A/D sample; data outside the strobe is inverted so stale values never match
  task automatic ain(input logic [11:0] a0, input logic [11:0] a1);
    @(posedge i_core_clk);
    o_ain_strobe <= 1'b1;
    o_ain0       <= a0;
    o_ain1       <= a1;
    @(posedge i_core_clk);
    o_ain_strobe <= 1'b0;
    o_ain0       <= ~a0;
    o_ain1       <= ~a1;
  endtask

  // One D/A word; low twelve bits are a two's complement code
  task automatic aout(input logic [15:0] w);
    @(posedge i_core_clk);
    o_aout_strobe <= 1'b1;
    o_aout1_word  <= w;
    @(posedge i_core_clk);
    o_aout_strobe <= 1'b0;
    o_aout1_word  <= ~w;
  endtask
endmodule

`default_nettype wire

// ===== sdio_map.svh
`ifndef SDIO_MAP_SVH
`define SDIO_MAP_SVH

// Register offsets (word index on the plain register port)
`define SDIO_REG_CTRL      4'h0
`define SDIO_REG_DIR       4'h1
`define SDIO_REG_OUT       4'h2
`define SDIO_REG_IN        4'h3
`define SDIO_REG_FRONT     4'h4
`define SDIO_REG_ATTEN     4'h5
`define SDIO_REG_STATUS    4'h6
`define SDIO_REG_SNAP      4'h7

// Control register fields
`define SDIO_CTRL_CLK_IN   0
`define SDIO_CTRL_CLK_OUT  1
`define SDIO_CTRL_TERM     2
`define SDIO_CTRL_FAST     3

// Front-end register fields (per analog input)
`define SDIO_FRONT_TERM0   0
`define SDIO_FRONT_TERM1   1
`define SDIO_FRONT_AC0     2
`define SDIO_FRONT_AC1     3

// Attenuator register fields
`define SDIO_ATT_BANK1_LSB 0
`define SDIO_ATT_BANK2     2

// Reset values
`define SDIO_CTRL_RESET    4'h0
`define SDIO_DIR_RESET     2'h0
`define SDIO_OUT_RESET     16'h0000

// Clocked digital input limit on the sample clock
`define SDIO_CLK_IN_MAX_HZ 10000000

`endif

// ===== sdio_pkg.sv
package sdio_pkg;

  // First output attenuator bank steps
  typedef enum logic [1:0]
  {
    SDIO_ATT_0DB  = 2'b00,
    SDIO_ATT_6DB  = 2'b01,
    SDIO_ATT_14DB = 2'b10,
    SDIO_ATT_20DB = 2'b11
  } sdio_att1_t;

  // Stream word: source of the captured sample
  typedef struct packed
  {
    logic [11:0] ain1;
    logic [11:0] ain0;
    logic [15:0] pins;
  } sdio_word_t;

endpackage

// ===== sdio_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdio_map.svh"

module sdio_port
  import sdio_pkg::*;
#(
  parameter int PORT_W = 8            // Pins per port
)
(
  input  wire logic                i_core_clk,
  input  wire logic                i_reset,
  input  wire logic                i_ce,
  // Register port
  input  wire logic [3:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output var  logic [31:0]         o_rdata,
  // Sample clock rate reported by the clock generator
  input  wire logic [31:0]         i_ain_rate_hz,
  // Converter strobes and data (same clock domain)
  input  wire logic                i_ain_strobe,
  input  wire logic [11:0]         i_ain0,
  input  wire logic [11:0]         i_ain1,
  input  wire logic                i_aout_strobe,
  input  wire logic [15:0]         i_aout1_word,
  output var  logic [11:0]         o_aout1_code,
  // Stream toward host memory
  output var  logic                o_stream_valid,
  input  wire logic                i_stream_ready,
  output var  sdio_word_t          o_stream_data,
  // Digital pins
  input  wire logic [2*PORT_W-1:0] i_digital_pins,
  output var  logic [2*PORT_W-1:0] o_digital_pins,
  output var  logic [2*PORT_W-1:0] o_digital_pins_oe,
  // Analog switch controls
  output var  logic                o_pin_term_en,
  output var  logic [1:0]          o_ain_term_en,
  output var  logic [1:0]          o_ain_ac_en,
  output var  logic [1:0]          o_att_bank1,
  output var  logic                o_att_bank2
);

  localparam int PW = 2 * PORT_W;

  logic [3:0]    ctrl;         // Mode and termination control
  logic [1:0]    dir;          // One direction bit per port
  logic [PW-1:0] out_val;      // Values driven on output ports
  logic [3:0]    front;        // Input termination and AC coupling
  logic [2:0]    atten;        // Attenuator selection
  logic [PW-1:0] sync1;        // Pin synchroniser stages
  logic [PW-1:0] sync2;        // Second stage, compared with third
  logic [PW-1:0] sync3;        // Third stage
  logic [PW-1:0] pins_stable;  // Filtered pin levels
  logic [PW-1:0] snap;         // Single-shot capture
  logic          too_fast;     // Sample clock above limit
  logic          refused;      // Sticky refusal flag
  logic          clk_in_on;    // Clocked input allowed and asked for
  logic          clk_out_on;   // Clocked output asked for
  logic [PW-1:0] dir_mask;     // Per-pin output enable
  logic [PW-1:0] pin_read;     // Port view as software sees it
  logic [11:0]   code_q;       // Last D/A code for output 1

  sdio_stream_if cap ();

  // Per-pin mask from the two port direction bits
  function automatic logic [PW-1:0] port_mask(input logic [1:0] d);
    port_mask = {{PORT_W{d[1]}}, {PORT_W{d[0]}}};
  endfunction

  // Mode decode; clocked input is gated off above the rate limit
  assign dir_mask   = port_mask(dir);
  assign too_fast   = (i_ain_rate_hz > 32'(`SDIO_CLK_IN_MAX_HZ));
  assign clk_in_on  = ctrl[`SDIO_CTRL_CLK_IN] && !too_fast;
  assign clk_out_on = ctrl[`SDIO_CTRL_CLK_OUT];
  // Output ports read their driven value, input ports the pins
  assign pin_read   = (dir_mask & out_val) | (~dir_mask & pins_stable);

  // Three-stage synchroniser; second and third must agree
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1       <= '0;
      sync2       <= '0;
      sync3       <= '0;
      pins_stable <= '0;
    end
    else if (i_ce)
    begin
      sync1 <= i_digital_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      // A level is taken only once two stages agree; one stray sample is filtered
      for (int k = 0; k < PW; k++)
      begin
        if (sync2[k] == sync3[k])
          pins_stable[k] <= sync3[k];
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctrl  <= `SDIO_CTRL_RESET;
      dir   <= `SDIO_DIR_RESET;
      front <= 4'h0;
      atten <= 3'h0;
    end
    else if (i_ce && i_wr)
    begin
      // Unmapped and read-only indices are ignored on write
      case (i_addr)
        `SDIO_REG_CTRL:  ctrl  <= i_wdata[3:0];
        `SDIO_REG_DIR:   dir   <= i_wdata[1:0];
        `SDIO_REG_FRONT: front <= i_wdata[3:0];
        `SDIO_REG_ATTEN: atten <= i_wdata[2:0];
        default:         ;
      endcase
    end
  end

  // Output value: software write, or output sample word when clocked
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      out_val <= `SDIO_OUT_RESET;
    else if (i_ce)
    begin
      // Sample word wins; software writes are ignored while clocked
      if (clk_out_on && i_aout_strobe)
        out_val <= i_aout1_word[PW-1:0];
      else if (!clk_out_on && i_wr && i_addr == `SDIO_REG_OUT)
        out_val <= i_wdata[PW-1:0];
    end
  end

  // Analog output 1 code taken from the shared word, 12-bit signed
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      code_q <= 12'h000;
    // Loaded in every mode, since the converter always takes the word
    else if (i_ce && i_aout_strobe)
      code_q <= i_aout1_word[11:0];
  end
  assign o_aout1_code = code_q;

  // Single-shot snapshot on a write to the snapshot register
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      snap <= '0;
    else if (i_ce && i_wr && i_addr == `SDIO_REG_SNAP)
      snap <= pin_read;
  end

  // Sticky refusal; a new refusal wins over a clear
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      refused <= 1'b0;
    else if (i_ce)
    begin
      // Checked first: a clear loses while the condition persists
      if (ctrl[`SDIO_CTRL_CLK_IN] && too_fast)
        refused <= 1'b1;
      else if (i_wr && i_addr == `SDIO_REG_STATUS && i_wdata[0])
        refused <= 1'b0;
    end
  end

  // Capture word: both inputs and pins on the same sample strobe
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cap.valid <= 1'b0;
      cap.data  <= '0;
    end
    else if (i_ce)
    begin
      if (clk_in_on && i_ain_strobe && cap.ready)
      begin
        cap.valid     <= 1'b1;
        cap.data.ain0 <= i_ain0;
        cap.data.ain1 <= i_ain1;
        cap.data.pins <= pin_read;
      end
      // Buffer took the word; drop valid unless a new one came
      else if (cap.ready)
        cap.valid <= 1'b0;
    end
  end

  // Stall buffer toward host memory; strobes are dropped while it is full
  sdio_skid u_skid (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_ce       (i_ce),
    .s_in       (cap.dst),
    .o_valid    (o_stream_valid),
    .i_ready    (i_stream_ready),
    .o_data     (o_stream_data)
  );

  // Read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= 32'h0;
    else if (i_ce)
    begin
      // Data stands for one cycle only
      o_rdata <= 32'h0;
      if (i_rd)
      begin
        case (i_addr)
          `SDIO_REG_CTRL:   o_rdata <= {28'h0, ctrl};
          `SDIO_REG_DIR:    o_rdata <= {30'h0, dir};
          `SDIO_REG_OUT:    o_rdata <= 32'(out_val);
          `SDIO_REG_IN:     o_rdata <= 32'(pin_read);
          `SDIO_REG_FRONT:  o_rdata <= {28'h0, front};
          `SDIO_REG_ATTEN:  o_rdata <= {29'h0, atten};
          `SDIO_REG_STATUS: o_rdata <= {30'h0, too_fast, refused};
          `SDIO_REG_SNAP:   o_rdata <= 32'(snap);
          default:          o_rdata <= 32'h0;
        endcase
      end
    end
  end

  // Pin drive and switch outputs
  assign o_digital_pins    = out_val;
  assign o_digital_pins_oe = dir_mask;
  assign o_pin_term_en     = ctrl[`SDIO_CTRL_TERM];
  assign o_ain_term_en     = {front[`SDIO_FRONT_TERM1], front[`SDIO_FRONT_TERM0]};
  assign o_ain_ac_en       = {front[`SDIO_FRONT_AC1], front[`SDIO_FRONT_AC0]};
  assign o_att_bank1       = atten[1:0];
  assign o_att_bank2       = atten[`SDIO_ATT_BANK2];

  // Checks on the register, pin and stream paths
  a_reset_idle: assert property (@(posedge i_core_clk)
    $fell(i_reset) |-> (o_digital_pins_oe == '0 && !o_pin_term_en))
    else $error("pins driven or termination on after reset");

  a_dir_oe: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_digital_pins_oe == {{PORT_W{dir[1]}}, {PORT_W{dir[0]}}})
    else $error("port enable differs from direction");

  a_readback_out: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_rd && i_addr == `SDIO_REG_IN) |=> ((o_rdata[PW-1:0] & $past(dir_mask))
      == ($past(out_val) & $past(dir_mask))))
    else $error("output port read did not return driven value");

  a_fast_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && too_fast && cap.ready) |=> !cap.valid)
    else $error("capture made above clock limit");

  a_capture_word: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && clk_in_on && i_ain_strobe && cap.ready) |=> (cap.valid && cap.data.ain0 == $past(i_ain0)))
    else $error("sample not captured");

  a_clk_out: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && clk_out_on && i_aout_strobe) |=> (out_val == $past(i_aout1_word[PW-1:0])))
    else $error("clocked output not from output word");

  a_single_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && !clk_out_on && i_wr && i_addr == `SDIO_REG_OUT) |=> (o_digital_pins == $past(i_wdata[PW-1:0])))
    else $error("single write not applied");

  a_term_bit: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wr && i_addr == `SDIO_REG_CTRL) |=> (o_pin_term_en == $past(i_wdata[`SDIO_CTRL_TERM])))
    else $error("termination enable not written");

  a_snap_take: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wr && i_addr == `SDIO_REG_SNAP) |=> (snap == $past(pin_read)))
    else $error("snapshot not taken from pin view");

  a_in_pins: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_rd && i_addr == `SDIO_REG_IN) |=> ((o_rdata[PW-1:0] & ~$past(dir_mask))
      == ($past(pins_stable) & ~$past(dir_mask))))
    else $error("input port read did not return pin levels");

  a_refuse_set: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && ctrl[`SDIO_CTRL_CLK_IN] && too_fast) |=> refused)
    else $error("refusal not flagged");

  a_refuse_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && !(ctrl[`SDIO_CTRL_CLK_IN] && too_fast) && i_wr && i_addr == `SDIO_REG_STATUS
      && i_wdata[0]) |=> !refused)
    else $error("refusal flag not cleared");

  a_pair_sample: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && clk_in_on && i_ain_strobe && cap.ready)
      |=> (cap.data.ain1 == $past(i_ain1) && cap.data.pins == $past(pin_read)))
    else $error("inputs and pins not taken on one strobe");

  a_out_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && clk_out_on && !i_aout_strobe) |=> $stable(out_val))
    else $error("clocked output changed without a sample");

  a_code_take: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_aout_strobe) |=> (o_aout1_code == $past(i_aout1_word[11:0])))
    else $error("output code not taken from output word");

  a_att_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wr && i_addr == `SDIO_REG_ATTEN)
      |=> ({o_att_bank2, o_att_bank1} == $past(i_wdata[`SDIO_ATT_BANK2:`SDIO_ATT_BANK1_LSB])))
    else $error("attenuator selection not written");

  a_front_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wr && i_addr == `SDIO_REG_FRONT)
      |=> (o_ain_term_en == $past(i_wdata[`SDIO_FRONT_TERM1:`SDIO_FRONT_TERM0])))
    else $error("input termination not written");

  a_ac_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wr && i_addr == `SDIO_REG_FRONT)
      |=> (o_ain_ac_en == $past(i_wdata[`SDIO_FRONT_AC1:`SDIO_FRONT_AC0])))
    else $error("coupling selection not written");

  a_stream_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_stream_valid && !(i_ce && i_stream_ready)) |=> (o_stream_valid && $stable(o_stream_data)))
    else $error("stream word lost during a stall");

  a_dir_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wr && i_addr == `SDIO_REG_DIR) |=> (dir == $past(i_wdata[1:0])))
    else $error("direction not written");

endmodule

`default_nettype wire

// ===== sdio_skid.sv
`timescale 1ns/10ps
`default_nettype none

// Two-entry buffer; data out of a register, no word lost on a stall
module sdio_skid
  import sdio_pkg::*;
(
  input  wire logic   i_core_clk,
  input  wire logic   i_reset,
  input  wire logic   i_ce,
  sdio_stream_if.dst  s_in,
  output var logic    o_valid,
  input  wire logic   i_ready,
  output var sdio_word_t o_data
);

  sdio_word_t mem [2];   // Two storage entries
  logic       wr_ptr;    // Next slot to fill
  logic       rd_ptr;    // Slot presented
  logic [1:0] count;     // Words held
  logic       push;
  logic       pop;

  // Ready is honest: only while a slot is free
  assign s_in.ready = (count != 2'd2);
  assign push       = i_ce && s_in.valid && s_in.ready;
  assign pop        = i_ce && o_valid && i_ready;
  assign o_valid    = (count != 2'd0);
  assign o_data     = mem[rd_ptr];

  // Storage write
  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= s_in.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// ===== sdio_stream_if.sv
`timescale 1ns/10ps
`default_nettype none

// Valid/ready stream of captured words between core and buffer
interface sdio_stream_if;
  import sdio_pkg::*;
  logic       valid;  // Word present
  logic       ready;  // Receiver takes word
  sdio_word_t data;   // Captured word
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdio_map.svh"

module testbench
  import sdio_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rdy = 1'b0, ext_en = 1'b1, ce = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rate = 32'h0, rdata;
  logic [15:0] pins, pout, poe, ext = 16'ha55a;
  logic [11:0] a0, a1, code;
  logic        astb, ostb, svalid, pterm, bank2;
  logic [15:0] oword;
  logic [1:0]  aterm, aac, bank1;
  sdio_word_t  sdata;
  int          errors = 0, checks = 0, n;

  // Clock at 10 MHz
  always #50 clk = ~clk;

  sdio_port sdio_port_i (.i_core_clk(clk), .i_reset(rst), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ain_rate_hz(rate),
    .i_ain_strobe(astb), .i_ain0(a0), .i_ain1(a1), .i_aout_strobe(ostb),
    .i_aout1_word(oword), .o_aout1_code(code), .o_stream_valid(svalid),
    .i_stream_ready(rdy), .o_stream_data(sdata), .i_digital_pins(pins),
    .o_digital_pins(pout), .o_digital_pins_oe(poe), .o_pin_term_en(pterm),
    .o_ain_term_en(aterm), .o_ain_ac_en(aac), .o_att_bank1(bank1), .o_att_bank2(bank2));

  sdio_far_model far_i (.i_core_clk(clk), .i_pins_out(pout), .i_pins_oe(poe), .i_ext(ext),
    .i_ext_en(ext_en), .o_pins(pins), .o_ain_strobe(astb), .o_ain0(a0), .o_ain1(a1),
    .o_aout_strobe(ostb), .o_aout1_word(oword));

  // Value compare; four-state so an unknown never matches
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(name, {8'h00, exp}, {8'h00, rdata});
  endtask

  // Let a few edges pass so level outputs and pin sync settle
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Wait for a word under a bound, compare it, then pop it with one ready cycle
  task automatic pop(input logic [39:0] exp, output bit got);
    got = 1'b0;
    for (int i = 0; i < 8 && !got; i++)
    begin
      idle(1);
      got = (svalid === 1'b1);
    end
    if (got)
    begin
      chk("stream", exp, sdata);
      @(posedge clk);
      rdy <= 1'b1;
      @(posedge clk);
      rdy <= 1'b0;
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well above the length of the sequence
  initial
  begin
    #2000000;
    errors++;
    complete_run();
  end

  initial
  begin
    bit got;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    // Quiet after reset: nothing driven, switches open
    chk("oe", 16'h0000, poe);
    chk("switches", 40'h0, {pterm, aterm, aac, bank1, bank2});
    rreg(`SDIO_REG_CTRL, 32'h0, "ctrl");
    rreg(`SDIO_REG_DIR, 32'h0, "dir");
    rreg(4'h8, 32'h0, "unmapped");
    idle(6);
    rreg(`SDIO_REG_IN, 32'ha55a, "in");
    // Snapshot keeps its view while released pins float up to the pull-ups
    wreg(`SDIO_REG_SNAP, 32'h0);
    ext_en <= 1'b0;
    idle(6);
    rreg(`SDIO_REG_SNAP, 32'ha55a, "snap");
    rreg(`SDIO_REG_IN, 32'hffff, "in");
    @(posedge clk);
    ext_en <= 1'b1;
    // Direction per byte port, readback of driven bits
    wreg(`SDIO_REG_OUT, 32'h1234);
    wreg(`SDIO_REG_DIR, 32'h1);
    idle(1);
    chk("oe", 16'h00ff, poe);
    chk("pins", 16'h1234, pout);
    idle(6);
    rreg(`SDIO_REG_IN, 32'ha534, "in");
    wreg(`SDIO_REG_DIR, 32'h2);
    idle(6);
    chk("oe", 16'hff00, poe);
    rreg(`SDIO_REG_IN, 32'h125a, "in");
    // Every front-end and attenuator setting
    for (int v = 0; v < 16; v++)
    begin
      wreg(`SDIO_REG_FRONT, v);
      wreg(`SDIO_REG_ATTEN, v & 7);
      wreg(`SDIO_REG_CTRL, (v & 1) << 2);
      idle(1);
      chk("term", v & 3, aterm);
      chk("ac", (v >> 2) & 3, aac);
      chk("att", v & 7, {bank2, bank1});
      chk("pinterm", v & 1, pterm);
    end
    // Clocked output: strobe ignored when off, followed when on
    wreg(`SDIO_REG_DIR, 32'h3);
    far_i.aout(16'hbeef);
    idle(2);
    chk("pins", 16'h1234, pout);
    wreg(`SDIO_REG_CTRL, 32'h2);
    far_i.aout(16'h9ffe);
    idle(2);
    chk("pins", 16'h9ffe, pout);
    chk("code", 12'hffe, code);
    wreg(`SDIO_REG_OUT, 32'h0f0f);
    idle(2);
    chk("pins", 16'h9ffe, pout);
    // Clocked input at the rate limit, receiver stalled, then drained
    wreg(`SDIO_REG_CTRL, 32'h0);
    wreg(`SDIO_REG_DIR, 32'h0);
    rate <= 32'd10000000;
    wreg(`SDIO_REG_CTRL, 32'h1);
    idle(6);
    for (int k = 0; k < 5; k++)
      far_i.ain(12'h800 + k, 12'h7f0 + k);
    idle(4);
    chk("valid", 1'b1, svalid);
    n = 0;
    for (int k = 0; k < 5; k++)
    begin
      pop({12'h7f0 + 12'(n), 12'h800 + 12'(n), 16'ha55a}, got);
      if (got)
        n++;
    end
    chk("kept", 40'd2, 40'(n));
    idle(2);
    chk("empty", 1'b0, svalid);
    // Above the limit nothing is captured and the refusal is flagged
    rate <= 32'd10000001;
    far_i.ain(12'h123, 12'h456);
    idle(4);
    chk("valid", 1'b0, svalid);
    rreg(`SDIO_REG_STATUS, 32'h3, "status");
    // A clear loses while the refusal condition persists
    wreg(`SDIO_REG_STATUS, 32'h1);
    rreg(`SDIO_REG_STATUS, 32'h3, "status");
    wreg(`SDIO_REG_CTRL, 32'h0);
    wreg(`SDIO_REG_STATUS, 32'h1);
    rreg(`SDIO_REG_STATUS, 32'h2, "status");
    // Clock enable low: a write is frozen out
    wreg(`SDIO_REG_CTRL, 32'h4);
    ce <= 1'b0;
    wreg(`SDIO_REG_DIR, 32'h3);
    ce <= 1'b1;
    idle(1);
    chk("frozen", 16'h0000, poe);
    // Reset in mid-run returns pins to input and opens termination
    wreg(`SDIO_REG_DIR, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    chk("oe", 16'h0000, poe);
    chk("pinterm", 1'b0, pterm);
    rreg(`SDIO_REG_DIR, 32'h0, "dir");
    complete_run();
  end
endmodule

`default_nettype wire
